// File: logic/ahs_axis_motion.sv
// Eight-axis smoothing, homing sequencer and position latch
//
// Notes on behaviour
// - servo fraction 0..1, one means no filter
// - per-axis constant independent, shared constant vector
// - step smoothing 1..16 filters pulse rate
// - step value one leaves rate unfiltered
// - step smoothing acts on step axes only
// - edge find slews until home changes, stops
// - home move starts forward if input low
// - polarity setting applies to both home sequences
// - home change starts deceleration at once
// - then creep back until switch toggles again
// - then move forward until index pulse
// - position defined zero at index
// - armed latch captures within 25 us
// - inputs 1-4 axes 1-4, 9-12 axes 5-8
// - arm enables each named axis independently
// - pending status one until captured
// - captured position readable per axis
// - capture disarms; software must re-arm
`timescale 1ns/1ns
`include "ahs_regs.svh"
module ahs_axis_motion #(
    parameter int LATCH_MAX_CYC = `AHS_LATCH_MAX_CYC // Capture deadline
) (
    input  wire logic              SYS_CLK,     // 250 MHz sample clock
    input  wire logic              NRST,        // Synchronous reset, low
    input  wire ahs_pkg::ahs_bus_s BUS,         // Register request
    output logic [31:0]            RDATA,       // Read data, next cycle
    input  wire logic [7:0][31:0]  ENC_POS,     // Main encoder counts
    input  wire logic [7:0]        HOME_IN,     // Home switch levels
    input  wire logic [7:0]        INDEX_IN,    // Encoder index pulses
    input  wire logic [11:0]       GEN_IN,      // General inputs 1..12
    output logic [7:0][15:0]       VEL_OUT,     // Smoothed velocities
    output logic [7:0]             POS_ZERO,    // Zero position, pulse
    output logic                   MOTION_DONE  // Home sequence finished
);
    ahs_pkg::ahs_state_s st_q;
    ahs_pkg::ahs_state_s st_d;
    logic [7:0][15:0]    target;
    logic [7:0][15:0]    vel;
    logic [7:0]          lat_in;
    logic [7:0]          home_act;
    logic [15:0]         home_vel;
    logic                hit;

    // Smoothing setting 1..16 to shift 0..15, out-of-range values clamped
    function automatic logic [3:0] ks_shift(input logic [4:0] ks);
        if (ks <= 5'h01) begin
            return 4'h0;
        end else if (ks >= `AHS_KS_MAX) begin
            return 4'hf;
        end else begin
            return 4'(ks - 5'h01);
        end
    endfunction : ks_shift

    function automatic logic [15:0] neg16(input logic [15:0] v);
        return 16'(~v + 16'h0001);
    endfunction : neg16

    // Latch input for each axis
    function automatic logic [3:0] lat_bit(input int unsigned ax);
        if (ax < 4) begin
            return 4'(ax);
        end else begin
            return 4'(ax + 4);
        end
    endfunction : lat_bit

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lat_in[i] = GEN_IN[lat_bit(i)];
        end
    end

    assign home_act = HOME_IN ^ st_q.polarity;
    assign hit = home_act[st_q.haxis] != st_q.href;

    always_comb begin
        case (st_q.hstate)
            ahs_pkg::HS_RUN: begin
                home_vel = st_q.hrev ? neg16(st_q.slew) : st_q.slew;
            end
            ahs_pkg::HS_BACK: begin
                home_vel = st_q.hrev ? `AHS_CREEP_VEL
                                     : neg16(`AHS_CREEP_VEL);
            end
            ahs_pkg::HS_INDEX: begin
                home_vel = `AHS_CREEP_VEL;
            end
            default: begin
                home_vel = 16'h0000;
            end
        endcase
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (st_q.hstate != ahs_pkg::HS_IDLE && st_q.haxis == 3'(i)) begin
                target[i] = home_vel;
            end else begin
                target[i] = st_q.jog[i];
            end
        end
    end

    for (genvar g = 0; g < 8; g++) begin : g_axis
        ahs_smoother u_smooth (
            .clk       (SYS_CLK),
            .nrst      (NRST),
            .target    ($signed(target[g])),
            .coef      (st_q.vect_mask[g] ? st_q.vect_tc
                                          : st_q.ind_tc[g]),
            .shift     (ks_shift(st_q.step_smooth[g])),
            .step_mode (st_q.step_mask[g]),
            .vel       (vel[g])
        );
    end

    assign VEL_OUT     = vel;
    assign POS_ZERO    = st_q.zero;
    assign MOTION_DONE = st_q.hdone;
    assign RDATA       = st_q.rdata;

    always_comb begin
        st_d      = st_q;
        st_d.zero = 8'h00;

        // Position latch, one cycle after the falling edge
        st_d.in_prev = lat_in;
        for (int i = 0; i < 8; i++) begin
            if (st_q.pending[i] && st_q.in_prev[i] && !lat_in[i]) begin
                st_d.latched[i] = ENC_POS[i];
                st_d.pending[i] = 1'b0;
            end
        end

        // Home sequencer
        case (st_q.hstate)
            ahs_pkg::HS_IDLE: begin
            end
            ahs_pkg::HS_RUN: begin
                if (hit) begin
                    st_d.hstate = ahs_pkg::HS_STOP1;
                end
            end
            ahs_pkg::HS_STOP1: begin
                if (vel[st_q.haxis] == 16'h0000) begin
                    if (st_q.hfull) begin
                        st_d.hstate = ahs_pkg::HS_BACK;
                        st_d.href   = home_act[st_q.haxis];
                    end else begin
                        st_d.hstate = ahs_pkg::HS_IDLE;
                        st_d.hdone  = 1'b1;
                    end
                end
            end
            ahs_pkg::HS_BACK: begin
                if (hit) begin
                    st_d.hstate = ahs_pkg::HS_INDEX;
                end
            end
            ahs_pkg::HS_INDEX: begin
                if (INDEX_IN[st_q.haxis]) begin
                    st_d.zero[st_q.haxis] = 1'b1;
                    st_d.hstate = ahs_pkg::HS_STOP2;
                end
            end
            ahs_pkg::HS_STOP2: begin
                if (vel[st_q.haxis] == 16'h0000) begin
                    st_d.hstate = ahs_pkg::HS_IDLE;
                    st_d.hdone  = 1'b1;
                end
            end
            default: begin
                st_d.hstate = ahs_pkg::HS_IDLE;
            end
        endcase

        // Register writes
        if (BUS.wr) begin
            case (BUS.addr & `AHS_GRP_MASK)
                `AHS_OFS_IND_TC: begin
                    st_d.ind_tc[BUS.addr[2:0]] = BUS.wdata[8:0];
                end
                `AHS_OFS_STEP_SMOOTH: begin
                    st_d.step_smooth[BUS.addr[2:0]] = BUS.wdata[4:0];
                end
                `AHS_OFS_JOG_VEL: begin
                    st_d.jog[BUS.addr[2:0]] = BUS.wdata[15:0];
                end
                default: begin
                end
            endcase
            case (BUS.addr)
                `AHS_OFS_LATCH: begin
                    // Re-arming wins over a capture in the same cycle
                    st_d.pending = st_d.pending | BUS.wdata[7:0];
                end
                `AHS_OFS_HOME: begin
                    // A new start is ignored while a sequence runs
                    if (BUS.wdata[`AHS_HOME_GO_BIT]
                        && st_q.hstate == ahs_pkg::HS_IDLE) begin
                        st_d.haxis  = BUS.wdata[`AHS_HOME_AXIS_LSB +: 3];
                        st_d.hfull  = BUS.wdata[`AHS_HOME_MODE_BIT];
                        st_d.hrev   = home_act[BUS.wdata[2:0]];
                        st_d.href   = home_act[BUS.wdata[2:0]];
                        st_d.hdone  = 1'b0;
                        st_d.hstate = ahs_pkg::HS_RUN;
                    end
                end
                `AHS_OFS_POLARITY: begin
                    st_d.polarity = BUS.wdata[7:0];
                end
                `AHS_OFS_STEP_AXES: begin
                    st_d.step_mask = BUS.wdata[7:0];
                end
                `AHS_OFS_VECT_AXES: begin
                    st_d.vect_mask = BUS.wdata[7:0];
                end
                `AHS_OFS_VECT_TC: begin
                    st_d.vect_tc = BUS.wdata[8:0];
                end
                `AHS_OFS_SLEW: begin
                    st_d.slew = BUS.wdata[15:0];
                end
                default: begin
                end
            endcase
        end

        // Register reads, data in the following cycle only
        st_d.rdata = 32'h0000_0000;
        if (BUS.rd) begin
            case (BUS.addr & `AHS_GRP_MASK)
                `AHS_OFS_IND_TC: begin
                    st_d.rdata = {23'h0, st_q.ind_tc[BUS.addr[2:0]]};
                end
                `AHS_OFS_STEP_SMOOTH: begin
                    st_d.rdata = {27'h0, st_q.step_smooth[BUS.addr[2:0]]};
                end
                `AHS_OFS_JOG_VEL: begin
                    st_d.rdata = {16'h0, st_q.jog[BUS.addr[2:0]]};
                end
                `AHS_OFS_LATCHED_POS: begin
                    st_d.rdata = st_q.latched[BUS.addr[2:0]];
                end
                default: begin
                end
            endcase
            case (BUS.addr)
                `AHS_OFS_LATCH: begin
                    st_d.rdata = {24'h0, st_q.pending};
                end
                `AHS_OFS_HOME: begin
                    st_d.rdata = {26'h0, st_q.hdone,
                                  st_q.hstate != ahs_pkg::HS_IDLE,
                                  st_q.hfull, st_q.haxis};
                end
                `AHS_OFS_POLARITY: begin
                    st_d.rdata = {24'h0, st_q.polarity};
                end
                `AHS_OFS_STEP_AXES: begin
                    st_d.rdata = {24'h0, st_q.step_mask};
                end
                `AHS_OFS_VECT_AXES: begin
                    st_d.rdata = {24'h0, st_q.vect_mask};
                end
                `AHS_OFS_VECT_TC: begin
                    st_d.rdata = {23'h0, st_q.vect_tc};
                end
                `AHS_OFS_SLEW: begin
                    st_d.rdata = {16'h0, st_q.slew};
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            st_q             <= '0;
            st_q.in_prev     <= 8'hff;
            st_q.vect_tc     <= `AHS_TC_RESET;
            st_q.ind_tc      <= {8{`AHS_TC_RESET}};
            st_q.step_smooth <= {8{`AHS_KS_RESET}};
            st_q.slew        <= `AHS_SLEW_RESET;
            st_q.hstate      <= ahs_pkg::HS_IDLE;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : ahs_axis_motion

// File: logic/ahs_pkg.sv
// Types shared by the homing, latch and smoothing logic
package ahs_pkg;

    typedef enum logic [2:0] {
        HS_IDLE,
        HS_RUN,
        HS_STOP1,
        HS_BACK,
        HS_INDEX,
        HS_STOP2
    } ahs_home_e;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ahs_bus_s;

    typedef struct packed {
        logic [7:0]       pending;
        logic [7:0]       in_prev;
        logic [7:0][31:0] latched;
        logic [7:0]       polarity;
        logic [7:0]       step_mask;
        logic [7:0]       vect_mask;
        logic [8:0]       vect_tc;
        logic [7:0][8:0]  ind_tc;
        logic [7:0][4:0]  step_smooth;
        logic [7:0][15:0] jog;
        logic [15:0]      slew;
        ahs_home_e        hstate;
        logic [2:0]       haxis;
        logic             hfull;
        logic             hrev;
        logic             href;
        logic             hdone;
        logic [7:0]       zero;
        logic [31:0]      rdata;
    } ahs_state_s;

    typedef struct packed {
        logic signed [23:0] acc;
    } ahs_smooth_s;

endpackage : ahs_pkg

// File: logic/ahs_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef AHS_REGS_SVH
`define AHS_REGS_SVH

`define AHS_OFS_LATCH        8'h00
`define AHS_OFS_HOME         8'h01
`define AHS_OFS_POLARITY     8'h02
`define AHS_OFS_STEP_AXES    8'h03
`define AHS_OFS_VECT_AXES    8'h04
`define AHS_OFS_VECT_TC      8'h05
`define AHS_OFS_SLEW         8'h06
`define AHS_OFS_IND_TC       8'h08
`define AHS_OFS_STEP_SMOOTH  8'h10
`define AHS_OFS_JOG_VEL      8'h18
`define AHS_OFS_LATCHED_POS  8'h20
`define AHS_GRP_MASK         8'hf8

`define AHS_HOME_AXIS_LSB    0
`define AHS_HOME_MODE_BIT    3
`define AHS_HOME_GO_BIT      4
`define AHS_HOME_BUSY_BIT    4
`define AHS_HOME_DONE_BIT    5

`define AHS_TC_ONE           9'h100
`define AHS_TC_RESET         9'h100
`define AHS_KS_RESET         5'h01
`define AHS_KS_MAX           5'h10
`define AHS_SLEW_RESET       16'h0400
`define AHS_CREEP_VEL        16'h0010

`define AHS_CLK_MHZ          250
`define AHS_LATCH_MAX_NS     25000
`define AHS_LATCH_MAX_CYC    (`AHS_LATCH_MAX_NS * `AHS_CLK_MHZ / 1000)

`endif

// File: logic/ahs_smoother.sv
// One axis profile smoother: servo fraction filter or step shift filter
`timescale 1ns/1ns
`include "ahs_regs.svh"
module ahs_smoother (
    input  wire logic               clk,       // Sample clock
    input  wire logic               nrst,      // Synchronous reset, low
    input  wire logic signed [15:0] target,    // Unfiltered velocity
    input  wire logic [8:0]         coef,      // Servo fraction, 256 is 1
    input  wire logic [3:0]         shift,     // Step smoothing minus one
    input  wire logic               step_mode, // Axis drives a step motor
    output logic signed [15:0]      vel        // Smoothed velocity
);
    ahs_pkg::ahs_smooth_s st_q;
    ahs_pkg::ahs_smooth_s st_d;
    logic signed [24:0] diff;
    logic signed [34:0] prod;
    logic signed [24:0] inc;

    assign vel = st_q.acc[23:8];

    always_comb begin
        st_d = st_q;
        diff = $signed({target, 8'h00}) - 25'(st_q.acc);
        prod = 35'(diff) * $signed({1'b0, coef});
        if (step_mode) begin
            inc = diff >>> shift;
        end else begin
            inc = 25'(prod >>> 8);
        end
        // Without this nudge a positive approach stalls short of the target
        if (inc == 25'h0 && diff != 25'h0 && (step_mode || coef != 9'h0)) begin
            inc = diff[24] ? -25'sd1 : 25'sd1;
        end
        st_d.acc = 24'(st_q.acc + inc);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : ahs_smoother

// File: tb/ahs_assertions.sv
// Port-level checker for the homing, latch and smoothing block
`timescale 1ns/1ns
module ahs_checker #(
    parameter int LATCH_MAX_CYC = 6250 // Capture deadline
) (
    input wire logic              SYS_CLK,    // Clock
    input wire logic              NRST,       // Reset, low
    input wire ahs_pkg::ahs_bus_s BUS,        // Register request
    input wire logic [31:0]       RDATA,      // Read data
    input wire logic [7:0][31:0]  ENC_POS,    // Encoder counts
    input wire logic [7:0]        HOME_IN,    // Home levels
    input wire logic [7:0]        INDEX_IN,   // Index marks
    input wire logic [11:0]       GEN_IN,     // General inputs
    input wire logic [7:0][15:0]  VEL_OUT,    // Velocities
    input wire logic [7:0]        POS_ZERO,   // Zero pulses
    input wire logic              MOTION_DONE // Sequence done
);
    logic [7:0]       lt;
    logic [7:0]       pm_q;
    logic [7:0]       gp_q;
    logic [7:0]       pol_q;
    logic [7:0][31:0] cv_q;
    logic [31:0]      sel;
    logic [2:0]       ha_q;
    logic             hd_q;
    logic             bsy_q;
    logic             go;
    assign lt  = {GEN_IN[11:8], GEN_IN[3:0]};
    assign sel = cv_q[BUS.addr[2:0]];
    assign go  = BUS.wr && BUS.addr == 8'h01 && BUS.wdata[4];
    // Shadow of pending, captures and the running home axis
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            pm_q  <= 8'h00;
            gp_q  <= 8'hff;
            pol_q <= 8'h00;
            cv_q  <= '0;
            bsy_q <= 1'b0;
        end else begin
            gp_q <= lt;
            pm_q <= (pm_q & ~(gp_q & ~lt))
                | ((BUS.wr && BUS.addr == 8'h00) ? BUS.wdata[7:0] : 8'h00);
            for (int k = 0; k < 8; k++) begin
                if (pm_q[k] && gp_q[k] && !lt[k]) cv_q[k] <= ENC_POS[k];
            end
            if (BUS.wr && BUS.addr == 8'h02) pol_q <= BUS.wdata[7:0];
            if (go && !bsy_q) begin
                bsy_q <= 1'b1;
                ha_q  <= BUS.wdata[2:0];
                hd_q  <= HOME_IN[BUS.wdata[2:0]] ^ pol_q[BUS.wdata[2:0]];
            end else if (MOTION_DONE) bsy_q <= 1'b0;
        end
    end
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!NRST);
    sequence s_start;
        go && !bsy_q;
    endsequence
    sequence s_move;
        ##[0:3] (VEL_OUT[ha_q] != 16'h0 && VEL_OUT[ha_q][15] == hd_q);
    endsequence
    property p_rd_idle;
        !BUS.rd |=> RDATA == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside a read");
    property p_pend;
        BUS.rd && BUS.addr == 8'h00 |=> RDATA == {24'h0, $past(pm_q)};
    endproperty
    a_pend: assert property (p_pend)
        else $error("pending status wrong");
    property p_lat;
        BUS.rd && BUS.addr[7:3] == 5'h04 |=> RDATA == $past(sel);
    endproperty
    a_lat: assert property (p_lat)
        else $error("latched position wrong");
    property p_dir;
        s_start |=> s_move;
    endproperty
    a_dir: assert property (p_dir)
        else $error("home start direction wrong");
    property p_stop;
        $rose(MOTION_DONE) |-> VEL_OUT[ha_q] == 16'h0;
    endproperty
    a_stop: assert property (p_stop)
        else $error("done while axis moving");
    property p_clr;
        go && MOTION_DONE |=> !MOTION_DONE;
    endproperty
    a_clr: assert property (p_clr)
        else $error("done kept over new start");
    property p_zidx;
        POS_ZERO != 8'h0 |-> (POS_ZERO & ~$past(INDEX_IN)) == 8'h0;
    endproperty
    a_zidx: assert property (p_zidx)
        else $error("zero without index");
    property p_zpulse;
        POS_ZERO != 8'h0 |=> POS_ZERO == 8'h0;
    endproperty
    a_zpulse: assert property (p_zpulse)
        else $error("zero pulse too long");
endmodule : ahs_checker
bind ahs_axis_motion ahs_checker #(.LATCH_MAX_CYC(LATCH_MAX_CYC)) u_chk (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .BUS(BUS), .RDATA(RDATA),
    .ENC_POS(ENC_POS), .HOME_IN(HOME_IN), .INDEX_IN(INDEX_IN),
    .GEN_IN(GEN_IN), .VEL_OUT(VEL_OUT), .POS_ZERO(POS_ZERO),
    .MOTION_DONE(MOTION_DONE)
);

// File: tb/ahs_plant.sv
// Far side: axis mechanics, home switches and index marks
`timescale 1ns/1ns
module ahs_plant #(
    parameter int HOME_AT = 20000 // Switch edges at plus and minus this
) (
    input  wire logic             clk,  // Sample clock
    input  wire logic [7:0][15:0] vel,  // Drive velocities
    output logic [7:0][31:0]      pos,  // Encoder counts
    output logic [7:0]            home, // Switch levels, 1 is +5V
    output logic [7:0]            index // Index marks, every 4096 counts
);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            home[i]  = $signed(pos[i]) >= HOME_AT
                || $signed(pos[i]) <= -HOME_AT;
            index[i] = pos[i][11:5] == 7'h00;
        end
    end
    initial pos = '0;
    always @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            pos[i] <= pos[i] + {{16{vel[i][15]}}, vel[i]};
        end
    end
endmodule : ahs_plant

// File: tb/testbench.sv
// Self-checking bench for the homing, latch and smoothing block
`timescale 1ns/1ns
module testbench;
    logic              clk;
    logic              nrst;
    ahs_pkg::ahs_bus_s bus;
    logic [31:0]       rdata;
    logic [7:0][31:0]  enc;
    logic [7:0]        home;
    logic [7:0]        index;
    logic [7:0]        pz;
    logic [11:0]       gen;
    logic [7:0][15:0]  vel;
    logic              done;
    int                failures;
    int                num_checks;
    int                pend;
    int                m;
    int                n;
    int                s;
    int                lat [8];
    int                zc [8];
    logic [31:0]       zp [8];
    logic [7:0]        ra [8] = '{8'h00, 8'h01, 8'h05, 8'h06,
                                  8'h08, 8'h17, 8'h20, 8'h30};
    logic [31:0]       rv [8] = '{32'h0, 32'h0, 32'h100, 32'h400,
                                  32'h100, 32'h1, 32'h0, 32'h0};
    ahs_axis_motion DUT (
        .SYS_CLK(clk), .NRST(nrst), .BUS(bus), .RDATA(rdata),
        .ENC_POS(enc), .HOME_IN(home), .INDEX_IN(index), .GEN_IN(gen),
        .VEL_OUT(vel), .POS_ZERO(pz), .MOTION_DONE(done)
    );
    ahs_plant plant (
        .clk(clk), .vel(vel), .pos(enc), .home(home), .index(index)
    );
    always #2 clk = ~clk;
    always @(negedge clk) begin
        for (int k = 0; k < 8; k++) begin
            if (pz[k] === 1'b1) begin
                zc[k]++;
                zp[k] = enc[k];
            end
        end
    end
    task automatic chk(input string nm, input logic [31:0] v, e);
        num_checks++;
        if (v !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, v);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        chk($sformatf("register %h", a), rdata, e);
        @(posedge clk);
    endtask : rc
    task automatic rst();
        nrst <= 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
    endtask : rst
    task automatic fall(input int i);
        int b;
        b = i < 4 ? i : i + 4;
        gen[b]   <= 1'b1;
        gen[7:4] <= 4'($urandom);
        @(posedge clk);
        gen[b] <= 1'b0;
        @(negedge clk);
        if (pend[i]) begin
            lat[i]  = enc[i];
            pend[i] = 1'b0;
        end
        @(posedge clk);
    endtask : fall
    task automatic smooth(input logic [7:0] a1, input logic [31:0] v1,
                          input logic [7:0] a2, input logic [31:0] v2,
                          input bit full);
        rst();
        wr(a1, v1);
        wr(a2, v2);
        wr(8'h1a, 32'd400);
        repeat (4) @(posedge clk);
        @(negedge clk);
        // Filtered only has to lag, exact curve is a design choice
        chk("velocity", full ? 32'(vel[2]) : 32'($signed(vel[2]) > 0
            && $signed(vel[2]) < 400), full ? 32'd400 : 32'h1);
    endtask : smooth
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #200000;
        failures++;
        print_verdict();
    end
    initial begin
        clk  = 1'b0;
        nrst = 1'b0;
        bus  = '0;
        gen  = '1;
        void'($urandom(32'he340a948));
        rst();
        foreach (ra[k]) rc(ra[k], rv[k]);
        wr(8'h30, $urandom);
        wr(8'h27, $urandom);
        rc(8'h30, 32'h0);
        rc(8'h27, 32'h0);
        for (int i = 0; i < 8; i++) begin
            m = $urandom_range(16, 1);
            wr(8'h10 + 8'(i), m);
            rc(8'h10 + 8'(i), m);
        end
        $display("test registers done");
        smooth(8'h12, 32'd16, 8'h0a, 32'h100, 1'b1);
        smooth(8'h0a, 32'h40, 8'h12, 32'h1, 1'b0);
        smooth(8'h04, 32'h04, 8'h05, 32'h40, 1'b0);
        smooth(8'h04, 32'h04, 8'h0a, 32'h40, 1'b1);
        smooth(8'h03, 32'h04, 8'h12, 32'h1, 1'b1);
        // Deep settings lag past the sampled span, so a light one is used
        smooth(8'h03, 32'h04, 8'h12, 32'd2, 1'b0);
        $display("test smoothing done");
        rst();
        // Bit 0 of h picks reverse start, bit 1 the full sequence
        for (int h = 0; h < 4; h++) begin
            // Unfiltered constant gives the hard stop after the switch
            wr(8'h08 + 8'(h), 32'h100);
            wr(8'h02, 32'(h[0]) << h);
            wr(8'h01, {27'h0, 1'b1, h[1], 3'(h)});
            if (h[1]) begin
                wr(8'h01, {27'h0, 1'b1, 1'b0, 3'(h)});
                rc(8'h01, {26'h0, 1'b0, 1'b1, 1'b1, 3'(h)});
            end
            n = 0;
            while (done !== 1'b1 && n < 5000) begin
                @(posedge clk);
                n++;
            end
            @(negedge clk);
            chk("done wait", 32'(n < 5000), 32'h1);
            s = enc[h];
            if (h[0]) s = -s;
            chk("zero count", zc[h], 32'(h[1]));
            if (h[1]) chk("zero position", 32'({zp[h][31], zp[h][11:6]}),
                32'(h[0]) << 6);
            else chk("edge stop", 32'(s >= 20000 && s < 24096),
                32'h1);
            rc(8'h01, {26'h0, 1'b1, 1'b0, h[1], 3'(h)});
        end
        $display("test homing done");
        rst();
        pend = 0;
        for (int i = 0; i < 8; i++) wr(8'h18 + 8'(i), $urandom_range(255, 1));
        for (int i = 0; i < 8; i++) begin
            m = $urandom_range(255, 0) | (1 << i);
            fall(i);
            wr(8'h00, m);
            pend |= m;
            repeat (2) @(posedge clk);
            rc(8'h00, pend);
            fall(i);
            rc(8'h00, pend);
            rc(8'h20 + 8'(i), lat[i]);
            fall(i);
            rc(8'h20 + 8'(i), lat[i]);
        end
        $display("test latch done");
        print_verdict();
    end
endmodule : testbench
